// *** logic/dla_pkg.sv ***
// package: register map, field layout and shared types of the debug link access bank
package dla_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets on the link access port
    localparam int          ADDR_W                = 4;
    localparam logic [3:0]  OFS_LINK_CONTROL_B    = 4'h3;
    localparam logic [3:0]  OFS_KEY_STATUS        = 4'h7;
    localparam logic [3:0]  OFS_RESET_REQUEST     = 4'h8;
    localparam logic [3:0]  OFS_LINK_CLOCK_CTRL   = 4'h9;
    localparam logic [3:0]  OFS_SYSTEM_CONTROL_A  = 4'hA;
    localparam logic [3:0]  OFS_SYSTEM_STATUS     = 4'hB;
    localparam logic [3:0]  OFS_CRC_RUN_STATUS    = 4'hC;

    ////////////////////////////////////////////////////////////////////////////////
    // bit positions
    localparam int BIT_LINK_DISABLE       = 2;
    localparam int BIT_USER_ROW_KEY       = 5;
    localparam int BIT_CLOCK_REQUEST      = 0;
    localparam int BIT_USER_ROW_GO        = 1;
    localparam int BIT_NVM_LOCKED         = 0;
    localparam int BIT_USER_ROW_READY     = 2;
    localparam int BIT_NVM_READY          = 3;
    localparam int BIT_SYSTEM_ASLEEP      = 4;
    localparam int BIT_SYSTEM_RESET       = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // values
    localparam logic [7:0] RESET_REQUEST_CODE = 8'h59;
    localparam logic [7:0] RESET_RELEASE_CODE = 8'h00;
    localparam logic [7:0] BYTE_ZERO          = 8'h00;

    typedef enum logic [1:0]
    {
        DLA_CLK_RESERVED = 2'b00,
        DLA_CLK_16MHZ    = 2'b01,
        DLA_CLK_8MHZ     = 2'b10,
        DLA_CLK_4MHZ     = 2'b11
    } dla_clksel_t;

    // flags coming from the system clock domain
    typedef struct packed
    {
        logic       reset_active;
        logic       asleep;
        logic       nvm_ready;
        logic       user_row_ready;
        logic       locked;
        logic [2:0] crc_state;
    } dla_sys_flags_t;

    localparam logic [7:0] SYS_FLAGS_RESET = 8'h08;

    // register access request from the link access layer
    typedef struct packed
    {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } dla_reg_req_t;

endpackage

// *** logic/dla_regs.sv ***
// debug link system access register bank
// Operation
// R1 - divider select picks 16, 8, 4 MHz
// R2 - divider select defaults to 4 MHz
// R3 - host keeps default rate unless brownout highest
// R4 - go bit starts user row programming
// R5 - host writes go only after data
// R6 - early go proceeds without the data
// R7 - go bit writable only with key decoded
// R8 - clock request bit requests system clock
// R9 - writing zero withdraws clock request
// R10 - clock request cleared when link disabled
// R11 - programming mode enable sets clock request
// R12 - reset flag shows system domain reset
// R13 - reading status clears reset flag
// R14 - reset flag includes held reset request
// R15 - asleep flag shows idle or deeper sleep
// R16 - nvm ready flag shows programming allowed
// R17 - host resets system after nvm programming
// R18 - user row ready flag shows start allowed
// R19 - locked flag shows device lock state
// R20 - crc run state is one-hot
// R21 - reset code holds system, zero releases
// R22 - link disable drops request, resets link
// R23 - key decode sets user row key status
// R24 - system flags synchronised before status
`timescale 1ns/100ps
module dla_regs
(
    input  wire logic                    i_mclk,
    input  wire logic                    i_reset_n,
    input  wire dla_pkg::dla_reg_req_t   i_reg_req,
    output logic [7:0]                   o_reg_rdata,
    input  wire logic                    i_link_enable,
    input  wire logic                    i_prog_mode,
    input  wire logic                    i_user_row_key_decoded,
    input  wire dla_pkg::dla_sys_flags_t i_sys_flags,
    output dla_pkg::dla_clksel_t         o_link_clock_select,
    output logic                         o_link_clock_request,
    output logic                         o_link_soft_reset,
    output logic                         o_system_clock_request,
    output logic                         o_sys_reset_hold,
    output logic                         o_user_row_program_go
);

    ////////////////////////////////////////////////////////////////////////////////
    // decode

    logic                   wr_control_b;
    logic                   wr_key_status;
    logic                   wr_reset_request;
    logic                   wr_clock_ctrl;
    logic                   wr_system_ctrl;
    logic                   rd_system_status;
    logic                   link_disabled_reg;
    logic                   write_ok;
    dla_pkg::dla_sys_flags_t flags_sync;
    logic [7:0]             flags_sync_bits;
    logic [7:0]             reset_request_value;

    // writes are dead while the link is disabled; only an enable revives it
    assign write_ok         = i_reg_req.wr && !link_disabled_reg && !i_link_enable;
    assign wr_control_b     = write_ok && (i_reg_req.addr == dla_pkg::OFS_LINK_CONTROL_B);
    assign wr_key_status    = write_ok && (i_reg_req.addr == dla_pkg::OFS_KEY_STATUS);
    assign wr_reset_request = write_ok && (i_reg_req.addr == dla_pkg::OFS_RESET_REQUEST);
    assign wr_clock_ctrl    = write_ok && (i_reg_req.addr == dla_pkg::OFS_LINK_CLOCK_CTRL);
    assign wr_system_ctrl   = write_ok && (i_reg_req.addr == dla_pkg::OFS_SYSTEM_CONTROL_A);
    assign rd_system_status = i_reg_req.rd && (i_reg_req.addr == dla_pkg::OFS_SYSTEM_STATUS);

    logic link_disable_write;
    assign link_disable_write = wr_control_b && i_reg_req.wdata[dla_pkg::BIT_LINK_DISABLE];

    ////////////////////////////////////////////////////////////////////////////////
    // system domain flags

    dla_sync
    #(
        .WIDTH     (8),
        .RESET_VAL (dla_pkg::SYS_FLAGS_RESET)
    )
    u_flag_sync
    (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_async   (i_sys_flags),
        .o_sync    (flags_sync_bits)
    );

    assign flags_sync = dla_pkg::dla_sys_flags_t'(flags_sync_bits); // R24

    dla_reset_request u_reset_request
    (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_wr      (wr_reset_request),
        .i_wdata   (i_reg_req.wdata),
        .o_value   (reset_request_value),
        .o_hold    (o_sys_reset_hold)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // link enable and disable

    logic soft_reset_reg;

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            link_disabled_reg <= 1'b0;
            soft_reset_reg    <= 1'b0;
        end
        else
        begin
            soft_reset_reg <= link_disable_write; // R22
            if (i_link_enable)
            begin
                link_disabled_reg <= 1'b0;
            end
            else if (link_disable_write)
            begin
                link_disabled_reg <= 1'b1; // R22
            end
        end
    end

    assign o_link_clock_request = !link_disabled_reg; // R22
    assign o_link_soft_reset    = soft_reset_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // link clock divider select

    dla_pkg::dla_clksel_t clksel_reg;

    // a reserved code is not taken: the rate stays where it was
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            clksel_reg <= dla_pkg::DLA_CLK_4MHZ; // R2
        end
        else if (i_link_enable || link_disable_write)
        begin
            clksel_reg <= dla_pkg::DLA_CLK_4MHZ; // R2
        end
        else if (wr_clock_ctrl && (i_reg_req.wdata[1:0] != dla_pkg::DLA_CLK_RESERVED))
        begin
            clksel_reg <= dla_pkg::dla_clksel_t'(i_reg_req.wdata[1:0]); // R1
        end
    end

    assign o_link_clock_select = clksel_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // user row write key status

    logic user_row_key_reg;

    // writing the bit ends the session; a decode in that same cycle still wins
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            user_row_key_reg <= 1'b0;
        end
        else if (link_disable_write)
        begin
            user_row_key_reg <= 1'b0; // R22
        end
        else if (i_user_row_key_decoded)
        begin
            user_row_key_reg <= 1'b1; // R23
        end
        else if (wr_key_status && i_reg_req.wdata[dla_pkg::BIT_USER_ROW_KEY])
        begin
            user_row_key_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // system control a

    logic clock_request_reg;
    logic user_row_go_reg;
    logic go_request;

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            clock_request_reg <= 1'b0;
        end
        else if (i_link_enable)
        begin
            clock_request_reg <= i_prog_mode; // R11
        end
        else if (link_disable_write)
        begin
            clock_request_reg <= 1'b0; // R10
        end
        else if (wr_system_ctrl)
        begin
            clock_request_reg <= i_reg_req.wdata[dla_pkg::BIT_CLOCK_REQUEST]; // R8 R9
        end
    end

    assign go_request = wr_system_ctrl && user_row_key_reg
                        && i_reg_req.wdata[dla_pkg::BIT_USER_ROW_GO]; // R7

    // the go pulse fires whether or not the data reached ram; the cpu copes
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            user_row_go_reg <= 1'b0;
        end
        else
        begin
            user_row_go_reg <= go_request; // R4 R6 R7
        end
    end

    assign o_system_clock_request = clock_request_reg && !link_disabled_reg; // R8
    assign o_user_row_program_go  = user_row_go_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // system status

    logic reset_flag_reg;
    logic reset_flag_set;

    assign reset_flag_set = flags_sync.reset_active || o_sys_reset_hold; // R12 R14

    // a live reset re-sets the flag in the same cycle as the read clear
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            reset_flag_reg <= 1'b0;
        end
        else if (reset_flag_set)
        begin
            reset_flag_reg <= 1'b1; // R12
        end
        else if (rd_system_status)
        begin
            reset_flag_reg <= 1'b0; // R13
        end
    end

    logic [7:0] status_value;

    always_comb
    begin
        status_value                                  = dla_pkg::BYTE_ZERO;
        status_value[dla_pkg::BIT_SYSTEM_RESET]       = reset_flag_reg;
        status_value[dla_pkg::BIT_SYSTEM_ASLEEP]      = flags_sync.asleep; // R15
        status_value[dla_pkg::BIT_NVM_READY]          = flags_sync.nvm_ready; // R16
        status_value[dla_pkg::BIT_USER_ROW_READY]     = flags_sync.user_row_ready; // R18
        status_value[dla_pkg::BIT_NVM_LOCKED]         = flags_sync.locked; // R19
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data

    logic [7:0] rdata_next;
    logic [7:0] rdata_reg;

    always_comb
    begin
        rdata_next = dla_pkg::BYTE_ZERO;
        case (i_reg_req.addr)
            dla_pkg::OFS_LINK_CONTROL_B:
            begin
                rdata_next[dla_pkg::BIT_LINK_DISABLE] = link_disabled_reg;
            end
            dla_pkg::OFS_KEY_STATUS:
            begin
                rdata_next[dla_pkg::BIT_USER_ROW_KEY] = user_row_key_reg;
            end
            dla_pkg::OFS_RESET_REQUEST:
            begin
                rdata_next = reset_request_value;
            end
            dla_pkg::OFS_LINK_CLOCK_CTRL:
            begin
                rdata_next[1:0] = clksel_reg;
            end
            dla_pkg::OFS_SYSTEM_CONTROL_A:
            begin
                rdata_next[dla_pkg::BIT_CLOCK_REQUEST] = clock_request_reg;
            end
            dla_pkg::OFS_SYSTEM_STATUS:
            begin
                rdata_next = status_value;
            end
            dla_pkg::OFS_CRC_RUN_STATUS:
            begin
                rdata_next[2:0] = flags_sync.crc_state; // R20
            end
            default:
            begin
                rdata_next = dla_pkg::BYTE_ZERO;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rdata_reg <= dla_pkg::BYTE_ZERO;
        end
        else if (i_reg_req.rd)
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_disable_write;
        link_disable_write;
    endsequence

    sequence s_link_cleared;
        (clksel_reg == dla_pkg::DLA_CLK_4MHZ) && !o_system_clock_request
        && !user_row_key_reg && !o_link_clock_request;
    endsequence

    sequence s_go_write;
        wr_system_ctrl && user_row_key_reg && i_reg_req.wdata[dla_pkg::BIT_USER_ROW_GO];
    endsequence

    a_enable_default_rate: assert property (i_link_enable |=> clksel_reg == dla_pkg::DLA_CLK_4MHZ) // R2
        else $error("clock select not at default after link enable");

    a_clksel_write_code: assert property (wr_clock_ctrl && !link_disable_write
        && (i_reg_req.wdata[1:0] != dla_pkg::DLA_CLK_RESERVED)
        |=> clksel_reg == $past(i_reg_req.wdata[1:0])) // R1
        else $error("clock select did not take written code");

    a_disable_clears_link: assert property (s_disable_write |=> s_link_cleared ##1 o_link_soft_reset == 1'b0) // R10
        else $error("link disable did not clear link state");

    a_go_needs_key: assert property (o_user_row_program_go
        |-> $past(user_row_key_reg) && $past(wr_system_ctrl)) // R7
        else $error("user row go without decoded key");

    a_go_pulse_fires: assert property (s_go_write |=> o_user_row_program_go ##1
        (o_user_row_program_go == $past(go_request))) // R4
        else $error("user row go pulse missing");

    a_clock_request_write: assert property (wr_system_ctrl
        |=> clock_request_reg == $past(i_reg_req.wdata[dla_pkg::BIT_CLOCK_REQUEST])) // R9
        else $error("clock request did not follow write");

    a_prog_mode_request: assert property (i_link_enable && i_prog_mode
        |=> o_system_clock_request && o_link_clock_request) // R11
        else $error("programming mode enable did not request system clock");

    a_reset_flag_set: assert property (reset_flag_set |=> reset_flag_reg) // R14
        else $error("reset flag not set while reset held");

    a_reset_flag_clear: assert property (rd_system_status && !reset_flag_set
        |=> !reset_flag_reg) // R13
        else $error("status read did not clear reset flag");

    a_reset_code_hold: assert property (wr_reset_request
        && (i_reg_req.wdata == dla_pkg::RESET_REQUEST_CODE)
        |=> o_sys_reset_hold && !link_disabled_reg ##1 reset_flag_reg) // R21
        else $error("reset code did not hold system");

    a_flag_sync_delay: assert property (##2 flags_sync.asleep == $past(i_sys_flags.asleep, 2)) // R24
        else $error("asleep flag not two cycles behind system");

    a_status_read_data: assert property (rd_system_status
        |=> o_reg_rdata[dla_pkg::BIT_NVM_LOCKED] == $past(flags_sync.locked)) // R19
        else $error("lock flag read back wrong");

endmodule

// *** logic/dla_reset_request.sv ***
// reset request register and its system reset hold decode
`timescale 1ns/100ps
module dla_reset_request
(
    input  wire logic       i_mclk,
    input  wire logic       i_reset_n,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_value,
    output logic            o_hold
);

    logic [7:0] request_reg;
    logic       hold_reg;

    // only the exact code holds the system; any other value releases it
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            request_reg <= dla_pkg::BYTE_ZERO;
            hold_reg    <= 1'b0;
        end
        else if (i_wr)
        begin
            request_reg <= i_wdata;
            hold_reg    <= (i_wdata == dla_pkg::RESET_REQUEST_CODE); // R21
        end
    end

    assign o_value = request_reg;
    assign o_hold  = hold_reg;

endmodule

// *** logic/dla_sync.sv ***
// two-flop level synchroniser, one per bit
`timescale 1ns/100ps
module dla_sync
#(
    parameter int               WIDTH     = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    input  wire logic             i_mclk,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            logic meta_reg;
            logic sync_reg;
            always_ff @(posedge i_mclk or negedge i_reset_n)
            begin
                if (!i_reset_n)
                begin
                    meta_reg <= RESET_VAL[g];
                    sync_reg <= RESET_VAL[g];
                end
                else
                begin
                    meta_reg <= i_async[g];
                    sync_reg <= meta_reg;
                end
            end
            assign o_sync[g] = sync_reg;
        end
    endgenerate

endmodule

// *** sim/dla_host_model.sv ***
// host side model: external programmer issuing register accesses over the link
`timescale 1ns/100ps
module dla_host_model
#(
    parameter bit BOD_AT_HIGHEST = 1'b1
)
(
    input  wire logic                   i_mclk,
    input  wire logic [7:0]             i_rdata,
    output dla_pkg::dla_reg_req_t       o_req
);
    logic row_loaded = 1'b0;
    logic early_ok   = 1'b0;

    initial o_req = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // drive after a falling edge, hold across the taking edge, then leave the bus idle
    task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge i_mclk);
        o_req = '{wr: w, rd: ~w, addr: a, wdata: d};
        @(negedge i_mclk);
        q = i_rdata;
        // idle bus carries no stale address or data
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // stands for the ram writes of the user row data through the system bus
    task automatic load_row();
        repeat (4) @(negedge i_mclk);
        row_loaded = 1'b1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] v;
        logic [7:0] q;
        v = d;
        if (a == dla_pkg::OFS_LINK_CLOCK_CTRL && v[1:0] != 2'h3 && !BOD_AT_HIGHEST)
            v[1:0] = 2'h3;
        // early_ok lets a scenario send the go bit ahead of the data on purpose
        if (a == dla_pkg::OFS_SYSTEM_CONTROL_A && v[1] && !row_loaded && !early_ok)
            load_row();
        access(1'b1, a, v, q);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        access(1'b0, a, 8'h00, q);
    endtask

    // after nvm programming the system is pulsed through the reset request register
    task automatic reset_system();
        wr(dla_pkg::OFS_RESET_REQUEST, dla_pkg::RESET_REQUEST_CODE);
        repeat (4) @(negedge i_mclk);
        wr(dla_pkg::OFS_RESET_REQUEST, dla_pkg::RESET_RELEASE_CODE);
    endtask
endmodule

// *** sim/tb.sv ***
// self-checking bench of the debug link access register bank
`timescale 1ns/100ps
module tb;
    typedef struct packed
    {
        logic [3:0] a;
        logic [7:0] d;
        logic [7:0] rb;
        logic [1:0] sel;
        logic       sck;
        logic       hold;
    } dla_row_t;

    localparam dla_row_t ROWS [10] = '{
        '{4'h9, 8'h01, 8'h01, 2'h1, 1'b0, 1'b0},
        '{4'h9, 8'h02, 8'h02, 2'h2, 1'b0, 1'b0},
        '{4'h9, 8'h00, 8'h02, 2'h2, 1'b0, 1'b0},
        '{4'h9, 8'h03, 8'h03, 2'h3, 1'b0, 1'b0},
        '{4'hA, 8'h01, 8'h01, 2'h3, 1'b1, 1'b0},
        '{4'hA, 8'h00, 8'h00, 2'h3, 1'b0, 1'b0},
        '{4'h8, 8'h59, 8'h59, 2'h3, 1'b0, 1'b1},
        '{4'h8, 8'h00, 8'h00, 2'h3, 1'b0, 1'b0},
        '{4'hC, 8'h07, 8'h00, 2'h3, 1'b0, 1'b0},
        '{4'hE, 8'hFF, 8'h00, 2'h3, 1'b0, 1'b0}
    };
    localparam logic [2:0] CRC  [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    localparam logic [7:0] STAT [4] = '{8'h10, 8'h08, 8'h04, 8'h01};

    logic                    mclk      = 1'b0;
    logic                    reset_n   = 1'b0;
    logic                    link_en   = 1'b0;
    logic                    prog_mode = 1'b0;
    logic                    key_dec   = 1'b0;
    dla_pkg::dla_sys_flags_t sys_fl    = 8'h08;
    dla_pkg::dla_sys_flags_t flags;
    dla_pkg::dla_reg_req_t   req;
    dla_pkg::dla_clksel_t    sel;
    logic [7:0]              rdata;
    logic [7:0]              v;
    logic                    link_req;
    logic                    soft_rst;
    logic                    sck;
    logic                    hold;
    logic                    go;
    int                      err_count = 0;
    int                      n_checks  = 0;
    int                      cyc       = 0;

    // the system domain answers a held reset request by entering reset
    assign flags = {sys_fl.reset_active | hold, sys_fl[6:0]};

    dla_host_model #(.BOD_AT_HIGHEST(1'b1)) i_host
    (
        .i_mclk (mclk),
        .i_rdata(rdata),
        .o_req  (req)
    );

    dla_regs i_dut
    (
        .i_mclk                (mclk),
        .i_reset_n             (reset_n),
        .i_reg_req             (req),
        .o_reg_rdata           (rdata),
        .i_link_enable         (link_en),
        .i_prog_mode           (prog_mode),
        .i_user_row_key_decoded(key_dec),
        .i_sys_flags           (flags),
        .o_link_clock_select   (sel),
        .o_link_clock_request  (link_req),
        .o_link_soft_reset     (soft_rst),
        .o_system_clock_request(sck),
        .o_sys_reset_hold      (hold),
        .o_user_row_program_go (go)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #5 mclk = ~mclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // bounded run: a hang counts as a mismatch
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic link_on(input logic pm);
        @(negedge mclk);
        prog_mode = pm;
        link_en   = 1'b1;
        @(negedge mclk);
        link_en = 1'b0;
    endtask

    task automatic key_pulse();
        @(negedge mclk);
        key_dec = 1'b1;
        @(negedge mclk);
        key_dec = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(6);
        reset_n = 1'b1;
        i_host.rd(4'hB, v);
        chk(v, 8'h01);
        i_host.rd(4'h9, v);
        chk(v, 8'h03);
        i_host.rd(4'hA, v);
        chk(v, 8'h00);
        for (int i = 0; i < 10; i++)
        begin
            i_host.wr(ROWS[i].a, ROWS[i].d);
            i_host.rd(ROWS[i].a, v);
            chk(v, ROWS[i].rb);
            chk({6'h00, sel}, {6'h00, ROWS[i].sel});
            chk({7'h00, sck}, {7'h00, ROWS[i].sck});
            chk({7'h00, hold}, {7'h00, ROWS[i].hold});
        end
        // drop the sticky reset flag left behind by the table
        i_host.rd(4'hB, v);
        for (int i = 0; i < 4; i++)
        begin
            sys_fl = {1'b0, 4'b1000 >> i, CRC[i]};
            tick(4);
            i_host.rd(4'hB, v);
            chk(v, STAT[i]);
            i_host.rd(4'hC, v);
            chk(v, {5'h00, CRC[i]});
        end
        i_host.wr(4'h8, 8'h59);
        chk({7'h00, hold}, 8'h01);
        tick(4);
        i_host.rd(4'hB, v);
        chk(v, 8'h21);
        i_host.rd(4'hB, v);
        chk(v, 8'h21);
        i_host.wr(4'h8, 8'h00);
        chk({7'h00, hold}, 8'h00);
        tick(4);
        i_host.rd(4'hB, v);
        i_host.rd(4'hB, v);
        chk(v, 8'h01);
        sys_fl.reset_active = 1'b1;
        tick(3);
        sys_fl.reset_active = 1'b0;
        tick(4);
        i_host.rd(4'hB, v);
        chk(v, 8'h21);
        i_host.rd(4'hB, v);
        chk(v, 8'h01);
        i_host.reset_system();
        i_host.wr(4'hA, 8'h02);
        chk({7'h00, go}, 8'h00);
        key_pulse();
        i_host.rd(4'h7, v);
        chk({7'h00, v[5]}, 8'h01);
        i_host.wr(4'hA, 8'h03);
        chk({6'h00, go, sck}, 8'h03);
        tick(1);
        chk({7'h00, go}, 8'h00);
        i_host.rd(4'hA, v);
        chk(v, 8'h01);
        i_host.row_loaded = 1'b0;
        i_host.early_ok   = 1'b1;
        i_host.wr(4'hA, 8'h02);
        chk({6'h00, go, sck}, 8'h02);
        i_host.wr(4'h9, 8'h01);
        link_on(1'b1);
        chk({5'h00, sel, sck}, 8'h07);
        link_on(1'b0);
        chk({7'h00, sck}, 8'h00);
        i_host.wr(4'hA, 8'h01);
        i_host.wr(4'h3, 8'h04);
        chk({5'h00, soft_rst, link_req, sck}, 8'h04);
        tick(1);
        chk({7'h00, soft_rst}, 8'h00);
        i_host.wr(4'h9, 8'h01);
        i_host.rd(4'h9, v);
        chk(v, 8'h03);
        i_host.rd(4'h3, v);
        chk(v, 8'h04);
        i_host.rd(4'h7, v);
        chk({7'h00, v[5]}, 8'h00);
        link_on(1'b1);
        chk({6'h00, link_req, sck}, 8'h03);
        sys_fl = 8'h08;
        @(negedge mclk);
        reset_n = 1'b0;
        tick(2);
        chk({3'h0, go, hold, sck, sel}, 8'h03);
        reset_n = 1'b1;
        i_host.rd(4'hB, v);
        chk(v, 8'h01);
        i_host.rd(4'hA, v);
        chk(v, 8'h00);
        tally_and_finish();
    end
endmodule
